// >>> design/pbps_pkg.sv
/*
 Package for the shared-pin port block: clock options, pin indices, reset values, timing.
 Assumes a single 40 MHz system clock and an active-high asynchronous system reset.
*/
package pbps_pkg;
   // ------------------------------------------------------------
   // Clock source options
   // ------------------------------------------------------------
   typedef enum logic [2:0] {
      PBPS_CLK_CRYSTAL,
      PBPS_CLK_LF_CRYSTAL,
      PBPS_CLK_CERAMIC,
      PBPS_CLK_EXT_RC,
      PBPS_CLK_EXT_CLOCK,
      PBPS_CLK_INT_RC
   } pbps_clk_type;
   // ------------------------------------------------------------
   // Port geometry and reset values
   // ------------------------------------------------------------
   localparam int PBPS_NUM_PINS = 6;
   localparam int PBPS_NUM_BIDIR = 5;
   localparam int PBPS_PIN_OSC_IN = 3;
   localparam int PBPS_PIN_OSC_OUT = 4;
   localparam int PBPS_PIN_RESET = 5;
   localparam logic [5:0] PBPS_RST_DIR = 6'h00;
   localparam logic [4:0] PBPS_RST_PULL = 5'h00;
   localparam logic [5:0] PBPS_RST_DATA = 6'h00;
   localparam logic [5:0] PBPS_RST_IN = 6'h00;
   localparam logic [5:0] PBPS_RST_OWN = 6'h00;
   localparam logic PBPS_RST_REQ = 1'b1;
   // ------------------------------------------------------------
   // Timing
   // ------------------------------------------------------------
   localparam int PBPS_CLK_PERIOD_NS = 25;
   localparam int PBPS_RST_PULSE_NS = 50;
   localparam int PBPS_RST_PULSE_CYC =
      (PBPS_RST_PULSE_NS + PBPS_CLK_PERIOD_NS - 1) / PBPS_CLK_PERIOD_NS;
endpackage

// >>> design/pbps_port.sv
/*
 Six-pin general-purpose port with pins taken over by reset and clock options.
 Assumes core-side direction, data and pull-up controls on the system clock and a pad
 cell that turns output enables into drive; pull-up enables feed the pad's resistors.
 Assumes the configuration inputs are static while the block is out of reset.
 Assumes the reset pin needs no filtering: any low that reaches the logic resets.
 Assumes the pad input of pin five is valid even when no clock runs.
 Assumes the status outputs are read on the system clock.
*/
`timescale 1ns/100ps
`default_nettype none
module pbps_port (
   // Clock and system reset
   input wire logic clock,
   input wire logic sys_rst,
   // Configuration
   input wire logic large_variant,
   input wire logic ext_reset_enable,
   input wire pbps_pkg::pbps_clk_type clock_option,
   // Core side controls
   input wire logic [5:0] port_dir,
   input wire logic [5:0] port_data,
   input wire logic [4:0] port_pullup,
   input wire logic ctrl_load,
   // Pads
   input wire logic [5:0] pad_in,
   output logic [5:0] pad_out,
   output logic [5:0] pad_oe,
   output logic [4:0] pad_pullup_en,
   // Status
   output logic [5:0] port_in,
   output logic [5:0] pin_is_port,
   output logic ext_reset_req,
   output logic ext_reset_seen
);
   // ------------------------------------------------------------
   // Reset input path
   // ------------------------------------------------------------
   logic rst_pin_n;
   logic reset_active;
   logic [5:0] pad_sync;

   // The pad input itself forms the reset, so it acts with no clock.
   assign rst_pin_n = ~(ext_reset_enable & ~pad_in[pbps_pkg::PBPS_PIN_RESET]);
   assign reset_active = sys_rst | ~rst_pin_n;

   genvar gi;
   generate
      for (gi = 0; gi < pbps_pkg::PBPS_NUM_PINS; gi++) begin : g_sync
         pbps_sync u_sync (
            .clock(clock),
            .sys_rst(reset_active),
            .async_in(pad_in[gi]),
            .sync_out(pad_sync[gi])
         );
      end
   endgenerate

   // ------------------------------------------------------------
   // Pin ownership
   // ------------------------------------------------------------
   logic [5:0] own;

   always_comb begin
      own = 6'h3F;
      if (ext_reset_enable) begin
         own[pbps_pkg::PBPS_PIN_RESET] = 1'b0;
      end
      unique case (clock_option)
         pbps_pkg::PBPS_CLK_CRYSTAL, pbps_pkg::PBPS_CLK_LF_CRYSTAL,
         pbps_pkg::PBPS_CLK_CERAMIC: begin
            own[pbps_pkg::PBPS_PIN_OSC_IN] = 1'b0;
            own[pbps_pkg::PBPS_PIN_OSC_OUT] = 1'b0;
         end
         pbps_pkg::PBPS_CLK_EXT_RC, pbps_pkg::PBPS_CLK_EXT_CLOCK: begin
            own[pbps_pkg::PBPS_PIN_OSC_IN] = 1'b0;
         end
         pbps_pkg::PBPS_CLK_INT_RC: begin
         end
         default: begin
            own[pbps_pkg::PBPS_PIN_OSC_IN] = 1'b0;
            own[pbps_pkg::PBPS_PIN_OSC_OUT] = 1'b0;
         end
      endcase
   end

   // ------------------------------------------------------------
   // Direction, data and pull-up registers
   // ------------------------------------------------------------
   logic [5:0] dir_q;
   logic [5:0] dir_d;
   logic [5:0] data_q;
   logic [5:0] data_d;
   logic [4:0] pull_q;
   logic [4:0] pull_d;

   always_comb begin
      dir_d = dir_q;
      data_d = data_q;
      pull_d = pull_q;
      // A load takes all three controls at once.
      if (ctrl_load) begin
         dir_d = port_dir;
         data_d = port_data;
         pull_d = port_pullup;
      end
      // Pin five has no pull-up and drives only low on the large variant.
      if (!large_variant) begin
         dir_d[pbps_pkg::PBPS_PIN_RESET] = 1'b0;
      end
      data_d[pbps_pkg::PBPS_PIN_RESET] = 1'b0;
      // A claimed pin never drives and never pulls up.
      dir_d = dir_d & own;
      pull_d = pull_d & own[4:0];
   end

   // Any reset source clears the controls asynchronously, so the pins float.
   always_ff @(posedge clock or posedge reset_active) begin
      if (reset_active) begin
         dir_q <= pbps_pkg::PBPS_RST_DIR;
         data_q <= pbps_pkg::PBPS_RST_DATA;
         pull_q <= pbps_pkg::PBPS_RST_PULL;
      end else begin
         dir_q <= dir_d;
         data_q <= data_d;
         pull_q <= pull_d;
      end
   end

   // ------------------------------------------------------------
   // Ownership register
   // ------------------------------------------------------------
   logic [5:0] own_q;
   logic [5:0] own_d;

   always_comb begin
      own_d = own;
   end

   // Cleared in reset, so every pin reads as claimed until the options apply.
   always_ff @(posedge clock or posedge reset_active) begin
      if (reset_active) begin
         own_q <= pbps_pkg::PBPS_RST_OWN;
      end else begin
         own_q <= own_d;
      end
   end

   // ------------------------------------------------------------
   // Pad input register
   // ------------------------------------------------------------
   logic [5:0] in_q;
   logic [5:0] in_d;

   always_comb begin
      // A claimed pin reads as zero.
      in_d = pad_sync & own;
   end

   // Pad levels read as zero while any reset source is active.
   always_ff @(posedge clock or posedge reset_active) begin
      if (reset_active) begin
         in_q <= pbps_pkg::PBPS_RST_IN;
      end else begin
         in_q <= in_d;
      end
   end

   // ------------------------------------------------------------
   // Reset request flag
   // ------------------------------------------------------------
   logic req_q;
   logic req_d;

   always_comb begin
      // The request falls at the first edge without a reset source.
      req_d = 1'b0;
   end

   // Set by any reset source, with or without a clock.
   always_ff @(posedge clock or posedge reset_active) begin
      if (reset_active) begin
         req_q <= pbps_pkg::PBPS_RST_REQ;
      end else begin
         req_q <= req_d;
      end
   end

   // ------------------------------------------------------------
   // External reset seen flag
   // ------------------------------------------------------------
   logic ext_seen_q;
   logic ext_seen_d;

   always_comb begin
      ext_seen_d = ext_seen_q;
      if (sys_rst) begin
         ext_seen_d = 1'b0;
      end
   end

   // A low on the reset pin sets the flag with no clock; the set wins over a clear.
   always_ff @(posedge clock or negedge rst_pin_n) begin
      if (!rst_pin_n) begin
         ext_seen_q <= 1'b1;
      end else begin
         ext_seen_q <= ext_seen_d;
      end
   end

   // ------------------------------------------------------------
   // Outputs
   // ------------------------------------------------------------
   assign pad_out = data_q;
   assign pad_oe = dir_q;
   assign pad_pullup_en = pull_q;
   assign port_in = in_q;
   assign pin_is_port = own_q;
   assign ext_reset_req = req_q;
   assign ext_reset_seen = ext_seen_q;
endmodule // pbps_port
`default_nettype wire

// >>> design/pbps_sync.sv
/*
 Three-flop synchroniser for one pad input.
 Assumes the input is asynchronous to clock; output follows once stages two and three agree.
*/
`timescale 1ns/100ps
`default_nettype none
module pbps_sync (
   // Clock and reset
   input wire logic clock,
   input wire logic sys_rst,
   // Data
   input wire logic async_in,
   output logic sync_out
);
   logic [2:0] stage_q;
   logic [2:0] stage_d;
   logic out_q;
   logic out_d;

   always_comb begin
      stage_d = {stage_q[1:0], async_in};
      out_d = (stage_q[2] == stage_q[1]) ? stage_q[2] : out_q;
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         stage_q <= 3'h7;
         out_q <= 1'b1;
      end else begin
         stage_q <= stage_d;
         out_q <= out_d;
      end
   end

   assign sync_out = out_q;
endmodule // pbps_sync
`default_nettype wire

// >>> verif/pbps_board.sv
/* Board model at the port pins.
 Assumes the bench drives ext_drv where ext_en is high. */
`timescale 1ns/100ps
`default_nettype none
module pbps_board (
   // Device side
   input wire logic [5:0] pad_out,
   input wire logic [5:0] pad_oe,
   input wire logic [4:0] pad_pullup_en,
   // Board side
   input wire logic [5:0] ext_drv,
   input wire logic [5:0] ext_en,
   output logic [5:0] pad_in
);
   // Device drive wins, then the board, then a pull-up.
   assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_drv)
      | (~pad_oe & ~ext_en & {1'b0, pad_pullup_en});
endmodule // pbps_board
`default_nettype wire

// >>> verif/pbps_port_chk.sv
/* Checker for the shared-pin port.
 Assumes it is bound to every pbps_port instance. */
`timescale 1ns/100ps
`default_nettype none
module pbps_port_chk (
   // Clock, reset, options
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic large_variant,
   input wire logic ext_reset_enable,
   input wire pbps_pkg::pbps_clk_type clock_option,
   // Core and pads
   input wire logic [5:0] port_dir,
   input wire logic [4:0] port_pullup,
   input wire logic ctrl_load,
   input wire logic [5:0] pad_in,
   input wire logic [5:0] pad_out,
   input wire logic [5:0] pad_oe,
   input wire logic [4:0] pad_pullup_en,
   input wire logic [5:0] pin_is_port,
   input wire logic ext_reset_req,
   input wire logic ext_reset_seen
);
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   sequence s_load;
      ctrl_load ##1 !ext_reset_req;
   endsequence
   chk_pin5_input: assert property (!large_variant |-> !pad_oe[5])
      else $error("pin five driven");
   chk_open_drain: assert property (pad_oe[5] |-> !pad_out[5])
      else $error("pin five drives high");
   chk_claim_clock: assert property (!ext_reset_req |-> pin_is_port[4:3] ==
      {clock_option inside {pbps_pkg::PBPS_CLK_EXT_RC, pbps_pkg::PBPS_CLK_EXT_CLOCK,
      pbps_pkg::PBPS_CLK_INT_RC}, clock_option == pbps_pkg::PBPS_CLK_INT_RC})
      else $error("clock claim");
   chk_claim_reset: assert property (!ext_reset_req |-> pin_is_port[5] == !ext_reset_enable)
      else $error("reset claim");
   chk_claim_mask: assert property ((pad_oe & ~pin_is_port) == 6'h00)
      else $error("claimed pin driven");
   chk_load_answer: assert property (s_load |-> pad_oe == ($past(port_dir) & pin_is_port
      & {large_variant, 5'h1F}) && pad_pullup_en == ($past(port_pullup) & pin_is_port[4:0]))
      else $error("load result");
   chk_reset_float: assert property (ext_reset_req |-> pad_oe == 6'h00 && !pad_pullup_en)
      else $error("pins active in reset");
   chk_low_resets: assert property (ext_reset_enable && !pad_in[5] |-> ext_reset_req
      && ext_reset_seen) else $error("low reset missed");
endmodule // pbps_port_chk
bind pbps_port pbps_port_chk u_chk (.clock, .sys_rst, .large_variant, .ext_reset_enable,
   .clock_option, .port_dir, .port_pullup, .ctrl_load, .pad_in, .pad_out, .pad_oe,
   .pad_pullup_en, .pin_is_port, .ext_reset_req, .ext_reset_seen);
`default_nettype wire

// >>> verif/pbps_port_tb.sv
/* Testbench for the shared-pin port.
 Assumes the checker and board model are compiled first. */
`timescale 1ns/100ps
`default_nettype none
module pbps_port_tb;
   logic clock = 1'b0, sys_rst = 1'b1, large_variant = 1'b1, ext_reset_enable = 1'b0;
   logic ctrl_load = 1'b0;
   pbps_pkg::pbps_clk_type clock_option = pbps_pkg::PBPS_CLK_INT_RC;
   logic [5:0] port_dir = 6'h00, port_data = 6'h00, ext_drv = 6'h3F, ext_en = 6'h3F, m;
   logic [4:0] port_pullup = 5'h00, pad_pullup_en;
   logic [5:0] pad_in, pad_out, pad_oe, port_in, pin_is_port;
   logic ext_reset_req, ext_reset_seen;
   int error_cnt = 0, n_checks = 0, cyc = 0;
   pbps_port dut (.clock, .sys_rst, .large_variant, .ext_reset_enable, .clock_option,
      .port_dir, .port_data, .port_pullup, .ctrl_load, .pad_in, .pad_out, .pad_oe,
      .pad_pullup_en, .port_in, .pin_is_port, .ext_reset_req, .ext_reset_seen);
   pbps_board board (.pad_out, .pad_oe, .pad_pullup_en, .ext_drv, .ext_en, .pad_in);
   initial begin
      forever #12.5 clock = ~clock;
   end
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, error_cnt);
      if (error_cnt == 0 && n_checks > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 3000) begin
         error_cnt++;
         end_sim();
      end
   end
   task automatic chk(input logic [5:0] got, input logic [5:0] exp);
      n_checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("MISMATCH %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic cfg(input logic lv, input logic ere, input pbps_pkg::pbps_clk_type opt);
      @(negedge clock);
      sys_rst = 1'b1;
      large_variant = lv;
      ext_reset_enable = ere;
      clock_option = opt;
      repeat (16) @(negedge clock);
      sys_rst = 1'b0;
      @(negedge clock);
      m = {~ere, opt >= pbps_pkg::PBPS_CLK_EXT_RC, opt == pbps_pkg::PBPS_CLK_INT_RC, 3'h7};
   endtask
   task automatic load(input logic [5:0] dir, input logic [4:0] pu);
      {port_dir, port_pullup, port_data, ctrl_load} = {dir, pu, 6'h3F, 1'b1};
      @(negedge clock);
      ctrl_load = 1'b0;
      @(negedge clock);
   endtask
   initial begin
      repeat (8) @(negedge clock);
      chk(pad_oe, 6'h00);
      for (int i = 0; i < 6; i++) begin
         cfg(1'b1, 1'b0, pbps_pkg::pbps_clk_type'(i));
         chk(pad_oe, 6'h00);
         chk(pin_is_port, m);
         load(6'h3F, 5'h1F);
         chk(pad_oe, m);
         chk(pad_out & m, m & 6'h1F);
         chk({1'b0, pad_pullup_en}, m & 6'h1F);
         load(6'h00, 5'h15);
         chk({1'b0, pad_pullup_en}, 6'h15 & m);
         ext_en = 6'h00;
         repeat (6) @(negedge clock);
         chk(port_in, 6'h15 & m);
         ext_en = 6'h3F;
         ext_drv = 6'h2A;
         repeat (6) @(negedge clock);
         chk(port_in, 6'h2A & m);
         ext_drv = 6'h3F;
      end
      cfg(1'b0, 1'b1, pbps_pkg::PBPS_CLK_INT_RC);
      load(6'h3F, 5'h1F);
      chk(pad_oe, 6'h1F);
      chk(pin_is_port, 6'h1F);
      ext_drv[5] = 1'b0;
      #5 chk(pad_oe, 6'h00);
      chk({5'h00, ext_reset_req}, 6'h01);
      repeat (3) @(negedge clock);
      ext_drv[5] = 1'b1;
      repeat (6) @(negedge clock);
      chk({ext_reset_seen, pad_pullup_en}, 6'h20);
      chk({ext_reset_req, pad_oe[4:0]}, 6'h00);
      cfg(1'b1, 1'b1, pbps_pkg::PBPS_CLK_CRYSTAL);
      load(6'h3F, 5'h1F);
      chk(pad_oe, m);
      chk({ext_reset_seen, pin_is_port[4:0]}, m);
      end_sim();
   end
endmodule // pbps_port_tb
`default_nettype wire
